// ===== hw/cache_timing_defines.svh
// constants for the board cache sram timing block
// Operation
// - wave pipelining applies only in 64-byte block mode, never with 32-byte blocks.
// - read latency sets data arrival; new read every latency minus wave cycles.
// - write steps four 16-byte indexes, each held write count, data one cycle later.
// - 9-bit mask selects per cycle whether tag and data write enables assert.
// - access times 4 to 15; 32-byte reads at least 5; index held whole access.
// - write enables last 0 to 9 cycles; mask zero none, all ones nine.
// - ssram clock low when idle, high exactly 2 cycles per access.
// - two identical ssram clock outputs, each with delay setting 0 or 1.
// - private reads pulse the ssram clock with every new index.
// - private writes pulse the ssram clock one cycle after each index.
// - clock sequence of one transaction finishes before the next type starts.
// - flowthrough and latch ssrams supported; no register-register or delayed write.
// - sysclk ratio 3-15, read and write speed 4-15, wave 0-4 accepted.
// - read-to-write gap 1-7, write-to-read gap 0-1, fill offset 1-7.
// - output and write enable active level selectable high or low.
// - cache size 1MB to 64MB, 64 or 32 byte blocks, ecc or parity.
// - read enables assert one cycle after first index, drop when fourth removed.
// - write count from config bits 11:8, read latency from bits 7:4.
`ifndef CACHE_TIMING_DEFINES_SVH
`define CACHE_TIMING_DEFINES_SVH

// =====================================================================
// register indexes
`define REG_TIMING_CONFIG   4'h0
`define REG_CONTROL_SET     4'h1
`define REG_COMMAND         4'h2
`define REG_STATUS          4'h3
`define REG_WDATA0          4'h4
`define REG_RDATA0          4'h8

// =====================================================================
// cache_timing_config fields
`define RD_SPD_FIELD        7:4
`define WR_SPD_FIELD        11:8
`define WE_CTL_FIELD        28:20

// =====================================================================
// cache_control_settings fields
`define WAVE_HI_BIT         31
`define WAVE_LO_FIELD       18:17
`define BLOCK64_BIT         0
`define SYNC_SRAM_BIT       1
`define OE_HIGH_BIT         2
`define WE_HIGH_BIT         3
`define CLKA_DLY_BIT        4
`define CLKB_DLY_BIT        5
`define WR2RD_BIT           6
`define RD2WR_FIELD         9:7
`define FILL_OFS_FIELD      12:10
`define SYSCLK_FIELD        16:13
`define ECC_BIT             19
`define SIZE_FIELD          23:20
`define VICTIM_FLUSH_BIT    26

// =====================================================================
// command and status fields
`define CMD_READ_BIT        0
`define CMD_WRITE_BIT       1
`define CMD_INDEX_FIELD     23:4
`define INDEX_W             20

// =====================================================================
// timing limits in cpu cycles
`define SPD_MIN             4'h4
`define SPD_MIN_32B_READ    4'h5
`define SPD_MAX             4'hf
`define WAVE_MAX            3'h4
`define RATE_MIN            4'h3
`define RD2WR_MIN           3'h1
`define SYSCLK_MIN          4'h3
`define SIZE_MAX            4'h6
`define MASK_BITS           4'h9
`define CLK_HIGH_CYCLES     2'h2
`define LAST_BEAT           2'h3
`define BEATS               3'h4
`define RESET_CONTROL       32'h0400_0001
`define RESET_CONFIG        32'h0060_0f6f

`endif

// ===== hw/cache_timing_pkg.sv
// types shared by the board cache timing block
package cache_timing_pkg;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_GAP   = 2'b01,
        ST_READ  = 2'b10,
        ST_WRITE = 2'b11
    } access_state_e;

endpackage : cache_timing_pkg

// ===== hw/ssram_clock_gen.sv
// ssram clock pulse generator with two delayable outputs
`include "cache_timing_defines.svh"
module ssram_clock_gen
    import cache_timing_pkg::*;
(
    input  wire logic       sys_clk_in,
    input  wire logic       rstn_in,
    input  wire logic       pulse_in,
    input  wire logic [1:0] delay_in,
    output logic            ssram_clock_a_out,
    output logic            ssram_clock_b_out
);

    // =================================================================
    // base pulse: high exactly two cycles, low otherwise
    logic [1:0] high_cnt;
    logic       ssram_clock;
    logic [1:0] delayed;
    logic [1:0] clk_q;

    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            high_cnt <= 2'h0;
        else if (pulse_in)
            high_cnt <= `CLK_HIGH_CYCLES;
        else if (high_cnt != 2'h0)
            high_cnt <= high_cnt - 2'h1;
    end

    assign ssram_clock = (high_cnt != 2'h0);

    // =================================================================
    // both outputs registered so delay 0 and 1 share one timing path
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : gen_out
            always_ff @(posedge sys_clk_in or negedge rstn_in)
            begin
                if (!rstn_in)
                begin
                    delayed[g] <= 1'b0;
                    clk_q[g]   <= 1'b0;
                end
                else
                begin
                    delayed[g] <= ssram_clock;
                    clk_q[g]   <= delay_in[g] ? delayed[g] : ssram_clock;
                end
            end
        end
    endgenerate

    assign ssram_clock_a_out = clk_q[0];
    assign ssram_clock_b_out = clk_q[1];

endmodule : ssram_clock_gen

// ===== hw/write_pulse_shaper.sv
// per-cycle write enable shaping from the write pulse mask
`include "cache_timing_defines.svh"
module write_pulse_shaper
    import cache_timing_pkg::*;
(
    input  wire logic       sys_clk_in,
    input  wire logic       rstn_in,
    input  wire logic       active_in,
    input  wire logic [3:0] cycle_in,
    input  wire logic [8:0] write_pulse_mask_in,
    input  wire logic       we_high_in,
    output logic            tag_ram_we_out,
    output logic            data_ram_we_out
);

    // =================================================================
    // cycles past the ninth never write; long accesses just idle there
    function automatic logic mask_hit(input logic [8:0] m, input logic [3:0] c);
        mask_hit = (c < `MASK_BITS) ? m[c] : 1'b0;
    endfunction : mask_hit

    logic we_level;

    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            we_level <= 1'b0;
        else
            we_level <= active_in && mask_hit(write_pulse_mask_in, cycle_in);
    end

    assign tag_ram_we_out  = we_level ~^ we_high_in;
    assign data_ram_we_out = we_level ~^ we_high_in;

endmodule : write_pulse_shaper

// ===== hw/board_cache_sram_timing.sv
// private read and write timing generator for the board cache srams
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`include "cache_timing_defines.svh"
module board_cache_sram_timing
    import cache_timing_pkg::*;
(
    input  wire logic                  sys_clk_in,
    input  wire logic                  rstn_in,
    input  wire logic [3:0]            addr_in,
    input  wire logic [31:0]           wdata_in,
    input  wire logic                  wr_in,
    input  wire logic                  rd_in,
    output logic      [31:0]           rdata_out,
    output logic      [`INDEX_W-1:0]   index_out,
    output logic      [31:0]           cache_data_out,
    output logic                       cache_data_oe_out,
    input  wire logic [31:0]           cache_data_in,
    output logic                       tag_ram_oe_out,
    output logic                       data_ram_oe_out,
    output logic                       tag_ram_we_out,
    output logic                       data_ram_we_out,
    output logic                       ssram_clock_a_out,
    output logic                       ssram_clock_b_out
);

    // =================================================================
    // software registers
    logic [31:0]         cache_timing_config;
    logic [31:0]         cache_control_settings;
    logic [31:0]         wdata_mem [4];
    logic [31:0]         rdata_mem [4];
    logic [`INDEX_W-1:0] index_base;

    // =================================================================
    // configuration snapshot taken when an access starts
    logic [3:0]  read_latency_cycles;
    logic [3:0]  write_cycle_count;
    logic [3:0]  rate;
    logic [8:0]  write_pulse_mask;
    logic        we_high;
    logic        oe_high;
    logic        sync_mode;
    logic [1:0]  clk_delay;

    // =================================================================
    // sequencing state
    access_state_e state;
    logic [7:0]  time_cnt;
    logic [7:0]  issue_time;
    logic [7:0]  capture_time;
    logic [2:0]  issued;
    logic [2:0]  captured;
    logic [1:0]  beat;
    logic [3:0]  beat_cyc;
    logic [2:0]  gap_cnt;
    logic        last_write;
    logic        pulse;
    logic        config_error;
    logic [31:0] sync_q1;
    logic [31:0] sync_q2;

    // =================================================================
    // decoded configuration, also used for the status error flag
    logic [2:0] wave_subtract_cycles;
    logic [3:0] rd_raw;
    logic [3:0] wr_raw;
    logic [3:0] rd_eff;
    logic [3:0] wr_eff;
    logic [3:0] rate_eff;
    logic       block64;
    logic       cmd_read;
    logic       cmd_write;
    logic       gap_needed;
    logic [2:0] gap_len;

    function automatic logic [3:0] clamp_spd(input logic [3:0] v, input logic [3:0] lo);
        clamp_spd = (v < lo) ? lo : v;
    endfunction : clamp_spd

    assign block64              = cache_control_settings[`BLOCK64_BIT];
    assign wave_subtract_cycles = {cache_control_settings[`WAVE_HI_BIT],
                                   cache_control_settings[`WAVE_LO_FIELD]};
    assign rd_raw = cache_timing_config[`RD_SPD_FIELD];
    assign wr_raw = cache_timing_config[`WR_SPD_FIELD];
    assign rd_eff = clamp_spd(rd_raw, block64 ? `SPD_MIN : `SPD_MIN_32B_READ);
    assign wr_eff = clamp_spd(wr_raw, `SPD_MIN);

    always_comb
    begin
        rate_eff = rd_eff;
        // wave ignored with 32-byte blocks; out of range values fall back to no wave
        if (block64 && wave_subtract_cycles <= `WAVE_MAX)
            rate_eff = rd_eff - {1'b0, wave_subtract_cycles};
        if (rate_eff < `RATE_MIN)
            rate_eff = `RATE_MIN;
    end

    // a clamped setting still runs; the flag only tells software it was bent
    assign config_error =
        (rd_eff - {1'b0, block64 ? wave_subtract_cycles : 3'h0} < `RATE_MIN)
        || (block64 && wave_subtract_cycles > `WAVE_MAX)
        || (rd_raw != rd_eff) || (wr_raw != wr_eff)
        || (cache_control_settings[`RD2WR_FIELD] < `RD2WR_MIN)
        || (cache_control_settings[`SYSCLK_FIELD] < `SYSCLK_MIN)
        || (cache_control_settings[`SIZE_FIELD] > `SIZE_MAX)
        || (cache_control_settings[`SYNC_SRAM_BIT]
            && !cache_control_settings[`VICTIM_FLUSH_BIT]);

    assign cmd_write  = wr_in && addr_in == `REG_COMMAND && wdata_in[`CMD_WRITE_BIT];
    assign cmd_read   = wr_in && addr_in == `REG_COMMAND && wdata_in[`CMD_READ_BIT]
                        && !cmd_write;
    // read-to-write and write-to-read spacing between accesses
    assign gap_needed = last_write ? cache_control_settings[`WR2RD_BIT] && cmd_read
                                   : cmd_write;
    assign gap_len    = last_write ? 3'h1 : cache_control_settings[`RD2WR_FIELD];

    // =================================================================
    // register writes; configuration changes mid-access are safe
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            cache_timing_config    <= `RESET_CONFIG;
            cache_control_settings <= `RESET_CONTROL;
            index_base             <= '0;
            for (int i = 0; i < 4; i++)
                wdata_mem[i] <= 32'h0;
        end
        else if (wr_in)
        begin
            if (addr_in == `REG_TIMING_CONFIG)
                cache_timing_config <= wdata_in;
            if (addr_in == `REG_CONTROL_SET)
                cache_control_settings <= wdata_in;
            if (addr_in == `REG_COMMAND && state == ST_IDLE)
                index_base <= wdata_in[`CMD_INDEX_FIELD];
            if (addr_in[3:2] == `REG_WDATA0 >> 2)
                wdata_mem[addr_in[1:0]] <= wdata_in;
        end
    end

    // =================================================================
    // read data pins pass two flops before capture
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            sync_q1 <= 32'h0;
            sync_q2 <= 32'h0;
        end
        else
        begin
            sync_q1 <= cache_data_in;
            sync_q2 <= sync_q1;
        end
    end

    // =================================================================
    // access sequencer
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            state               <= ST_IDLE;
            time_cnt            <= 8'h0;
            issue_time          <= 8'h0;
            capture_time        <= 8'h0;
            issued              <= 3'h0;
            captured            <= 3'h0;
            beat                <= 2'h0;
            beat_cyc            <= 4'h0;
            gap_cnt             <= 3'h0;
            last_write          <= 1'b0;
            pulse               <= 1'b0;
            read_latency_cycles <= `SPD_MIN;
            write_cycle_count   <= `SPD_MIN;
            rate                <= `SPD_MIN;
            write_pulse_mask    <= 9'h0;
            we_high             <= 1'b1;
            oe_high             <= 1'b1;
            sync_mode           <= 1'b0;
            clk_delay           <= 2'h0;
            index_out           <= '0;
            for (int i = 0; i < 4; i++)
                rdata_mem[i] <= 32'h0;
        end
        else
        begin
            pulse <= 1'b0;
            case (state)
                ST_IDLE, ST_GAP:
                begin
                    if (state == ST_GAP && gap_cnt != 3'h0)
                        gap_cnt <= gap_cnt - 3'h1;
                    else if (state == ST_GAP)
                        state <= ST_IDLE;
                    else if ((cmd_read || cmd_write) && gap_needed && gap_len != 3'h0)
                    begin
                        // command is dropped; software retries after the gap
                        state   <= ST_GAP;
                        gap_cnt <= gap_len - 3'h1;
                        last_write <= cmd_write;
                    end
                    else if (cmd_read || cmd_write)
                    begin
                        read_latency_cycles <= rd_eff;
                        write_cycle_count   <= wr_eff;
                        rate                <= rate_eff;
                        write_pulse_mask    <= cache_timing_config[`WE_CTL_FIELD];
                        we_high             <= cache_control_settings[`WE_HIGH_BIT];
                        oe_high             <= cache_control_settings[`OE_HIGH_BIT];
                        sync_mode           <= cache_control_settings[`SYNC_SRAM_BIT];
                        clk_delay           <= {cache_control_settings[`CLKB_DLY_BIT],
                                                cache_control_settings[`CLKA_DLY_BIT]};
                        index_out    <= {wdata_in[`INDEX_W+3:6], 2'h0};
                        time_cnt     <= 8'h0;
                        issue_time   <= {4'h0, rate_eff};
                        capture_time <= {4'h0, rd_eff};
                        issued       <= 3'h1;
                        captured     <= 3'h0;
                        beat         <= 2'h0;
                        beat_cyc     <= 4'h0;
                        last_write   <= cmd_write;
                        state        <= cmd_write ? ST_WRITE : ST_READ;
                        pulse        <= cmd_read && cache_control_settings[`SYNC_SRAM_BIT];
                    end
                end
                ST_READ:
                begin
                    time_cnt <= time_cnt + 8'h1;
                    if (issued < `BEATS && time_cnt + 8'h1 == issue_time)
                    begin
                        index_out[1:0] <= issued[1:0];
                        issued         <= issued + 3'h1;
                        issue_time     <= issue_time + {4'h0, rate};
                        pulse          <= sync_mode;
                    end
                    if (time_cnt + 8'h1 == capture_time)
                    begin
                        rdata_mem[captured[1:0]] <= sync_q2;
                        captured     <= captured + 3'h1;
                        capture_time <= capture_time + {4'h0, rate};
                        if (captured[1:0] == `LAST_BEAT)
                            state <= ST_IDLE;
                    end
                end
                ST_WRITE:
                begin
                    time_cnt <= time_cnt + 8'h1;
                    pulse    <= sync_mode && beat_cyc == 4'h0;
                    if (beat_cyc == write_cycle_count - 4'h1)
                    begin
                        beat_cyc <= 4'h0;
                        beat     <= beat + 2'h1;
                        if (beat == `LAST_BEAT)
                            state <= ST_IDLE;
                        else
                            index_out[1:0] <= beat + 2'h1;
                    end
                    else
                        beat_cyc <= beat_cyc + 4'h1;
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // =================================================================
    // write data follows each index by one cycle and is held to the access end
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            cache_data_out    <= 32'h0;
            cache_data_oe_out <= 1'b0;
        end
        else
        begin
            cache_data_out    <= wdata_mem[beat];
            cache_data_oe_out <= state == ST_WRITE;
        end
    end

    // =================================================================
    // output enables: one cycle after the first index, off when the last leaves
    logic oe_level;

    assign oe_level        = state == ST_READ && time_cnt != 8'h0;
    assign tag_ram_oe_out  = oe_level ~^ oe_high;
    assign data_ram_oe_out = oe_level ~^ oe_high;

    // =================================================================
    // register read port, data one cycle after the strobe
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            rdata_out <= 32'h0;
        else if (rd_in)
        begin
            case (addr_in)
                `REG_TIMING_CONFIG: rdata_out <= cache_timing_config;
                `REG_CONTROL_SET:   rdata_out <= cache_control_settings;
                `REG_COMMAND:       rdata_out <= {8'h0, index_base, 4'h0};
                `REG_STATUS:        rdata_out <= {20'h0, rate, captured, config_error,
                                                  beat, state};
                `REG_RDATA0, `REG_RDATA0 + 4'h1, `REG_RDATA0 + 4'h2, `REG_RDATA0 + 4'h3:
                    rdata_out <= rdata_mem[addr_in[1:0]];
                default:            rdata_out <= 32'h0;
            endcase
        end
        else
            rdata_out <= 32'h0;
    end

    // =================================================================
    // submodules
    write_pulse_shaper u_shaper (
        .sys_clk_in          (sys_clk_in),
        .rstn_in             (rstn_in),
        .active_in           (state == ST_WRITE),
        .cycle_in            (beat_cyc),
        .write_pulse_mask_in (write_pulse_mask),
        .we_high_in          (we_high),
        .tag_ram_we_out      (tag_ram_we_out),
        .data_ram_we_out     (data_ram_we_out)
    );

    ssram_clock_gen u_clock (
        .sys_clk_in        (sys_clk_in),
        .rstn_in           (rstn_in),
        .pulse_in          (pulse),
        .delay_in          (clk_delay),
        .ssram_clock_a_out (ssram_clock_a_out),
        .ssram_clock_b_out (ssram_clock_b_out)
    );

endmodule : board_cache_sram_timing

// ===== bench/board_cache_sram_timing_asserts.sv
// port checker for the board cache sram timing block
`include "cache_timing_defines.svh"
module board_cache_sram_timing_asserts
(
    input wire logic                sys_clk_in,
    input wire logic                rstn_in,
    input wire logic [3:0]          addr_in,
    input wire logic [31:0]         wdata_in,
    input wire logic                wr_in,
    input wire logic                rd_in,
    input wire logic [31:0]         rdata_out,
    input wire logic [`INDEX_W-1:0] index_out,
    input wire logic                cache_data_oe_out,
    input wire logic                tag_ram_oe_out,
    input wire logic                ssram_clock_a_out,
    input wire logic                ssram_clock_b_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // =====================================================================
    // control shadow, exact only while control is written between accesses
    logic [31:0] ctl;
    always_ff @(posedge sys_clk_in or negedge rstn_in)
        if (!rstn_in) ctl <= `RESET_CONTROL;
        else if (wr_in && addr_in == `REG_CONTROL_SET) ctl <= wdata_in;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);
    sequence two_high;
        ssram_clock_a_out [*2] ##1 !ssram_clock_a_out;
    endsequence
    a_clk_width: assert property ($rose(ssram_clock_a_out) |-> two_high)
        else $error("ssram clock a high time wrong");
    a_clk_twin: assert property (ctl[4] == ctl[5] |-> ssram_clock_a_out == ssram_clock_b_out)
        else $error("ssram clocks differ");
    a_clk_skew: assert property (ctl[4] && !ctl[5] |-> ssram_clock_a_out == $past(ssram_clock_b_out))
        else $error("ssram clock a delay wrong");
    a_read_pulse: assert property ($changed(index_out) && tag_ram_oe_out == ctl[2] && ctl[1]
        && !ctl[4] |-> ##2 $rose(ssram_clock_a_out)) else $error("read index without pulse");
    a_write_pulse: assert property ($changed(index_out) && cache_data_oe_out && ctl[1]
        && !ctl[4] |-> ##3 $rose(ssram_clock_a_out)) else $error("write pulse late");
    a_index_step: assert property ($changed(index_out) && index_out[1:0] != 2'h0
        |-> index_out == $past(index_out) + 20'h1) else $error("index did not step");
    a_data_oe_run: assert property ($rose(cache_data_oe_out) |-> cache_data_oe_out [*8])
        else $error("write data dropped early");
    a_rdata_quiet: assert property (rdata_out != 32'h0 |-> $past(rd_in))
        else $error("read data without read strobe");
endmodule : board_cache_sram_timing_asserts

// ===== bench/sram_model.sv
// behavioural tag and data srams with active-high enables
module sram_model
(
    input  wire logic        sys_clk_in,
    input  wire logic        slow_in,
    input  wire logic [19:0] index_in,
    input  wire logic [31:0] data_in,
    input  wire logic        oe_in,
    input  wire logic        we_in,
    output logic      [31:0] data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [16];
    logic [31:0] last;
    logic [3:0]  idx_d1, idx_d2;
    always @(posedge sys_clk_in)
    begin
        idx_d1 <= index_in[3:0];
        idx_d2 <= idx_d1;
        if (we_in) mem[index_in[3:0]] <= data_in;
        if (oe_in) last <= data_out;
    end
    // released bus shows the inverse of the last value, never a held copy
    assign data_out = oe_in ? mem[slow_in ? idx_d2 : idx_d1] : ~last;
endmodule : sram_model

// ===== bench/tb.sv
// self-checking bench for the board cache sram timing block
`include "cache_timing_defines.svh"
bind board_cache_sram_timing board_cache_sram_timing_asserts chk (.sys_clk_in, .rstn_in,
    .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .index_out, .cache_data_oe_out,
    .tag_ram_oe_out, .ssram_clock_a_out, .ssram_clock_b_out);
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk_in, rstn_in, wr_in, rd_in, slow, cache_data_oe_out;
    logic        tag_ram_oe_out, data_ram_oe_out, tag_ram_we_out, data_ram_we_out;
    logic        ssram_clock_a_out, ssram_clock_b_out;
    logic [3:0]  addr_in;
    logic [19:0] index_out;
    logic [31:0] wdata_in, rdata_out, cache_data_out, cache_data_in, s, w [4];
    logic [8:0]  masks [4] = '{9'h1ff, 9'h006, 9'h000, 9'h001};
    int          mismatches, check_count, we_cycles;
    board_cache_sram_timing dut (.sys_clk_in, .rstn_in, .addr_in, .wdata_in, .wr_in, .rd_in,
        .rdata_out, .index_out, .cache_data_out, .cache_data_oe_out, .cache_data_in,
        .tag_ram_oe_out, .data_ram_oe_out, .tag_ram_we_out, .data_ram_we_out,
        .ssram_clock_a_out, .ssram_clock_b_out);
    sram_model srams (.sys_clk_in, .slow_in(slow), .index_in(index_out),
        .data_in(cache_data_out), .oe_in(tag_ram_oe_out & data_ram_oe_out),
        .we_in(data_ram_we_out & tag_ram_we_out), .data_out(cache_data_in));
    always #12.5 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) we_cycles += int'(data_ram_we_out === 1'b1);
    // =====================================================================
    // bus tasks
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge sys_clk_in);
        wr_in <= 1'b0;
        @(posedge sys_clk_in);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge sys_clk_in);
        rd_in <= 1'b0;
        #1 v = rdata_out;
        @(posedge sys_clk_in);
    endtask : rd
    // a command landing in a gap is dropped, so it is reissued
    task automatic go(input logic [31:0] cmd);
        s = 32'h0;
        for (int n = 0; n < 8 && s[1] == 1'b0; n++)
        begin
            wr(`REG_COMMAND, cmd);
            rd(`REG_STATUS, s);
        end
        for (int n = 0; n < 300 && s[1:0] != 2'h0; n++)
            rd(`REG_STATUS, s);
    endtask : go
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results
    initial
    begin
        {sys_clk_in, rstn_in, wr_in, rd_in, slow, addr_in, wdata_in} = '0;
        void'($urandom(9));
        repeat (8) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        @(posedge sys_clk_in);
        rd(`REG_TIMING_CONFIG, s);
        check("config reset", `RESET_CONFIG, s);
        rd(`REG_CONTROL_SET, s);
        check("control reset", `RESET_CONTROL, s);
        rd(4'hc, s);
        check("unmapped read", 32'h0, s);
        $display("reset test done");
        masks[3] = 9'($urandom) | 9'h001;
        for (int i = 0; i < 4; i++)
        begin
            wr(`REG_CONTROL_SET, 32'h0404_008f | (32'(i & 1) << 4));
            wr(`REG_TIMING_CONFIG, {3'h0, masks[i], 20'h00a60});
            for (int k = 0; k < 4; k++)
            begin
                s = $urandom;
                if (masks[i] != 9'h0) w[k] = s;
                wr(4'(4 + k), s);
            end
            we_cycles = 0;
            go(32'h00a5_c3a2);
            check("write enable cycles", 32'(4 * $countones(masks[i])), 32'(we_cycles));
            check("last write index", 32'h000a_5c3b, 32'(index_out));
            slow <= i[1];
            go(32'h00a5_c3a1);
            for (int k = 0; k < 4; k++)
            begin
                rd(4'(8 + k), s);
                check("read beat", w[k], s);
            end
            rd(`REG_STATUS, s);
            check("repeat rate", 32'h4, 32'(s[11:8]));
            $display("pass %0d done", i);
        end
        results();
    end
    initial
    begin
        #2_000_000;
        mismatches++;
        results();
    end
endmodule : tb
